// file: rtl/upbp_pkg.sv
// package: shared constants for the BMC link ends
`default_nettype none
package upbp_pkg;
    // 250 MHz core clock, 4 ns period
    localparam int CLK_PERIOD_PS = 4000;
    // nominal unit interval, 300 kbit/s -> 3333 ns
    localparam int UI_NS         = 3333;
    localparam int UI_CYC        = (UI_NS * 1000) / CLK_PERIOD_PS;
    localparam int HALF_UI_CYC   = UI_CYC / 2;
    // half/full interval boundary at three quarters of a unit interval
    localparam int THRESH_CYC    = (UI_CYC * 3) / 4;
    // idle when no edge seen for this many unit intervals
    localparam int IDLE_UI       = 12;
    localparam int IDLE_CYC      = UI_CYC * IDLE_UI;
    localparam int CNT_W         = 16;
    // plug orientation codes
    localparam logic SEL_PIN_A   = 1'h0;
    localparam logic SEL_PIN_B   = 1'h1;
endpackage
`default_nettype wire

// file: rtl/upbp_link_if.sv
// interface: the shared configuration-channel wire between two ends
`default_nettype none
interface upbp_link_if;
    // device end drives one of two pins, enables are active low
    logic pin_a_o;
    logic pin_a_oe_n;
    logic pin_b_o;
    logic pin_b_oe_n;
    // far end drives the wire it mates with
    logic far_o;
    logic far_oe_n;
    // resolved wire levels; idle bias reads high
    logic pin_a_i;
    logic pin_b_i;
    logic far_i;
    logic orient_b;

    always_comb
    begin
        pin_a_i = !pin_a_oe_n ? pin_a_o
                : (!orient_b && !far_oe_n) ? far_o : 1'b1;
        pin_b_i = !pin_b_oe_n ? pin_b_o
                : (orient_b && !far_oe_n) ? far_o : 1'b1;
        far_i   = orient_b ? pin_b_i : pin_a_i;
    end

    modport dev (output pin_a_o, pin_a_oe_n, pin_b_o, pin_b_oe_n,
                 input  pin_a_i, pin_b_i);
    modport far (output far_o, far_oe_n, input far_i);
endinterface
`default_nettype wire

// file: rtl/upbp_far_end.sv
// far-end partner: BMC transmit and receive on its single wire
`default_nettype none
module upbp_far_end
    import upbp_pkg::*;
#(
    parameter int UI = upbp_pkg::UI_CYC
)(
    // clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_srst,
    // link
    upbp_link_if.far  link,
    // user transmit
    input  wire logic i_tx_start,
    input  wire logic i_tx_bit,
    input  wire logic i_tx_last,
    output logic      o_tx_ready,
    output logic      o_tx_busy,
    // user receive
    output logic      o_rx_valid,
    output logic      o_rx_bit
);
    import upbp_pkg::*;

    logic [CNT_W-1:0] t_reg;
    logic             lvl_reg;
    logic             bit_reg;
    logic             last_reg;
    logic             busy_reg;
    logic             tail_reg;
    logic             s1_reg;
    logic             s2_reg;
    logic             p_reg;
    logic [CNT_W-1:0] gap_reg;
    logic             half_reg;
    logic             v_reg;
    logic             b_reg;

    // ****************************************************************
    // transmit
    // ****************************************************************
    assign o_tx_ready = busy_reg && !tail_reg && !last_reg
                        && (t_reg == CNT_W'(UI - 1));
    assign o_tx_busy  = busy_reg;

    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            busy_reg <= 1'b0;
            tail_reg <= 1'b0;
            lvl_reg  <= 1'b0;
            t_reg    <= '0;
            bit_reg  <= 1'b0;
            last_reg <= 1'b0;
        end
        else if (!busy_reg)
        begin
            lvl_reg <= 1'b0;
            t_reg   <= '0;
            if (i_tx_start)
            begin
                busy_reg <= 1'b1;
                bit_reg  <= i_tx_bit;
                last_reg <= i_tx_last;
            end
        end
        else if (tail_reg && t_reg == CNT_W'(UI / 2 - 1))
        begin
            // closing level held half a UI, so release never reads as a bit
            busy_reg <= 1'b0;
            tail_reg <= 1'b0;
            t_reg    <= '0;
        end
        else if (t_reg == CNT_W'(UI - 1))
        begin
            t_reg    <= '0;
            lvl_reg  <= !lvl_reg;
            if (last_reg)
                tail_reg <= 1'b1;
            bit_reg  <= i_tx_bit;
            last_reg <= i_tx_last;
        end
        else
        begin
            t_reg <= t_reg + CNT_W'(1);
            if (t_reg == CNT_W'(UI / 2 - 1) && bit_reg && !tail_reg)
                lvl_reg <= !lvl_reg;
        end
    end

    always_comb
    begin
        link.far_o    = lvl_reg;
        link.far_oe_n = !busy_reg;
    end

    // ****************************************************************
    // receive: tolerant of a lost first edge
    // ****************************************************************
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            p_reg  <= 1'b1;
        end
        else
        begin
            s1_reg <= link.far_i;
            s2_reg <= s1_reg;
            p_reg  <= s2_reg;
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst || busy_reg)
        begin
            gap_reg  <= '0;
            half_reg <= 1'b0;
            v_reg    <= 1'b0;
            b_reg    <= 1'b0;
        end
        else
        begin
            v_reg <= 1'b0;
            if (s2_reg != p_reg)
            begin
                gap_reg <= '0;
                // a lost first edge just makes one long gap, dropped
                if (gap_reg > CNT_W'(2 * UI))
                    half_reg <= 1'b0;
                else if (gap_reg >= CNT_W'((UI * 3) / 4))
                begin
                    v_reg    <= 1'b1;
                    b_reg    <= 1'b0;
                    half_reg <= 1'b0;
                end
                else if (half_reg)
                begin
                    v_reg    <= 1'b1;
                    b_reg    <= 1'b1;
                    half_reg <= 1'b0;
                end
                else
                    half_reg <= 1'b1;
            end
            else if (gap_reg != '1)
                gap_reg <= gap_reg + CNT_W'(1);
        end
    end

    assign o_rx_valid = v_reg;
    assign o_rx_bit   = b_reg;
endmodule
`default_nettype wire

// file: rtl/upbp_dev_end.sv
// device end: BMC encoder, decoder and squelch for one port
//
// Notes on behaviour
// - every bit cell starts with an edge
// - a one adds a mid-cell edge
// - disparity stays within half a bit
// - preamble begins by driving low
// - receiver survives a lost first edge
// - closing edge after the last bit
// - driver enabled only while sending
// - one selected pin per connection
// - one talker; others high impedance
// - squelch reports bus idle except while sending
// - traffic on the biased pin
// - one copy per port, two total
// - pin chosen from plug orientation
// - decoded bits passed to core
`default_nettype none
module upbp_dev_end
    import upbp_pkg::*;
#(
    parameter int PORT_INDEX = 0,
    parameter int UI_DIV     = upbp_pkg::UI_CYC,
    parameter int IDLE       = upbp_pkg::IDLE_CYC
)(
    // clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_srst,
    // link
    upbp_link_if.dev  link,
    // attach
    input  wire logic i_attached,
    input  wire logic i_orient_b,
    // core transmit
    input  wire logic i_tx_start,
    input  wire logic i_tx_bit,
    input  wire logic i_tx_last,
    output logic      o_tx_ready,
    output logic      o_tx_busy,
    // core receive
    output logic      o_rx_valid,
    output logic      o_rx_bit,
    output logic      o_bus_idle
);
    import upbp_pkg::*;

    // each port instantiates its own copy; PORT_INDEX tells them apart

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_PRE  = 4'h2,
        ST_DATA = 4'h4,
        ST_TAIL = 4'h8
    } upbp_tx_e;

    upbp_tx_e         st_reg;
    logic             sel_reg;
    logic [CNT_W-1:0] div_reg;
    logic             lvl_reg;
    logic             bit_reg;
    logic             last_reg;
    logic             s1_reg;
    logic             s2_reg;
    logic             p_reg;
    logic [CNT_W-1:0] gap_reg;
    logic [CNT_W-1:0] quiet_reg;
    logic             half_reg;
    logic             v_reg;
    logic             b_reg;
    logic             tick;
    logic             mid;
    logic             rx_pin;

    function automatic logic gap_is_full(input logic [CNT_W-1:0] g);
        gap_is_full = g >= CNT_W'((UI_DIV * 3) / 4);
    endfunction

    // ****************************************************************
    // pin selection latched at attach
    // ****************************************************************
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
            sel_reg <= SEL_PIN_A;
        else if (!i_attached)
            sel_reg <= i_orient_b;
        // held for the whole connection, no switching
    end

    // ****************************************************************
    // unit interval divider
    // ****************************************************************
    assign tick = (div_reg == CNT_W'(UI_DIV - 1));
    assign mid  = (div_reg == CNT_W'(UI_DIV / 2 - 1));

    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst || st_reg == ST_IDLE || tick)
            div_reg <= '0;
        else
            div_reg <= div_reg + CNT_W'(1);
    end

    // ****************************************************************
    // transmitter
    // ****************************************************************
    // no bit is taken while the preamble cell runs
    assign o_tx_ready = (st_reg == ST_DATA) && tick && !last_reg;
    assign o_tx_busy  = (st_reg != ST_IDLE);

    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            st_reg   <= ST_IDLE;
            lvl_reg  <= 1'b0;
            bit_reg  <= 1'b0;
            last_reg <= 1'b0;
        end
        else
        begin
            case (st_reg)
                ST_IDLE:
                begin
                    lvl_reg <= 1'b0;
                    if (i_tx_start && i_attached)
                    begin
                        st_reg   <= ST_PRE;
                        bit_reg  <= i_tx_bit;
                        last_reg <= i_tx_last;
                    end
                end
                // first cell held low a full UI before any edge
                ST_PRE:
                    if (tick)
                    begin
                        lvl_reg  <= !lvl_reg;
                        st_reg   <= ST_DATA;
                    end
                ST_DATA:
                    if (tick)
                    begin
                        lvl_reg <= !lvl_reg;
                        if (last_reg)
                            st_reg <= ST_TAIL;
                        bit_reg  <= i_tx_bit;
                        last_reg <= i_tx_last;
                    end
                    else if (mid && bit_reg)
                        lvl_reg <= !lvl_reg;
                // hold the closing level one half UI, then release
                ST_TAIL:
                    if (mid)
                        st_reg <= ST_IDLE;
                default:
                    st_reg <= ST_IDLE;
            endcase
        end
    end

    // drive only the selected, biased pin; release otherwise
    always_comb
    begin
        link.pin_a_o    = lvl_reg;
        link.pin_b_o    = lvl_reg;
        link.pin_a_oe_n = !(o_tx_busy && sel_reg == SEL_PIN_A);
        link.pin_b_oe_n = !(o_tx_busy && sel_reg == SEL_PIN_B);
    end

    // ****************************************************************
    // receiver: synchroniser, edge gaps, squelch
    // ****************************************************************
    assign rx_pin = (sel_reg == SEL_PIN_B) ? link.pin_b_i : link.pin_a_i;

    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            p_reg  <= 1'b1;
        end
        else
        begin
            s1_reg <= rx_pin;
            s2_reg <= s1_reg;
            p_reg  <= s2_reg;
        end
    end

    // own transmission is ignored, so an echo is never decoded
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst || o_tx_busy)
        begin
            gap_reg  <= '0;
            half_reg <= 1'b0;
            v_reg    <= 1'b0;
            b_reg    <= 1'b0;
        end
        else
        begin
            v_reg <= 1'b0;
            if (s2_reg != p_reg)
            begin
                gap_reg <= '0;
                if (gap_reg > CNT_W'(2 * UI_DIV))
                    half_reg <= 1'b0;
                else if (gap_is_full(gap_reg))
                begin
                    v_reg    <= 1'b1;
                    b_reg    <= 1'b0;
                    half_reg <= 1'b0;
                end
                else if (half_reg)
                begin
                    v_reg    <= 1'b1;
                    b_reg    <= 1'b1;
                    half_reg <= 1'b0;
                end
                else
                    half_reg <= 1'b1;
            end
            else if (gap_reg != '1)
                gap_reg <= gap_reg + CNT_W'(1);
        end
    end

    // squelch: runs always, even while sending
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
            quiet_reg <= '0;
        else if (s2_reg != p_reg)
            quiet_reg <= '0;
        else if (quiet_reg != CNT_W'(IDLE))
            quiet_reg <= quiet_reg + CNT_W'(1);
    end

    assign o_bus_idle = (quiet_reg == CNT_W'(IDLE)) && !o_tx_busy;
    assign o_rx_valid = v_reg;
    assign o_rx_bit   = b_reg;
endmodule
`default_nettype wire

// file: verif/upbp_checker.sv
// checker: wire-level assertions on the shared link
`default_nettype none
module upbp_checker #(
    parameter int U = 16
)(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_srst,
    // link wires
    input wire logic pin_a_o,
    input wire logic pin_a_oe_n,
    input wire logic pin_b_o,
    input wire logic pin_b_oe_n,
    input wire logic far_o,
    input wire logic far_oe_n,
    input wire logic orient_b
);
    // ****************************************
    // run-length counters
    // ****************************************
    logic       s_o;
    logic       s_oe_n;
    logic [7:0] d_cnt_reg;
    logic [7:0] f_cnt_reg;
    assign s_o    = orient_b ? pin_b_o : pin_a_o;
    assign s_oe_n = orient_b ? pin_b_oe_n : pin_a_oe_n;
    // counters clear when undriven, so only in-frame runs count
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst || s_oe_n || $changed(s_o))
            d_cnt_reg <= 8'h00;
        else
            d_cnt_reg <= d_cnt_reg + 8'h01;
    end
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst || far_oe_n || $changed(far_o))
            f_cnt_reg <= 8'h00;
        else
            f_cnt_reg <= f_cnt_reg + 8'h01;
    end
    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);
    property p_one_pin;
        pin_a_oe_n || pin_b_oe_n;
    endproperty
    a_one_pin: assert property (p_one_pin)
        else $error("both pins driven");
    property p_pin_sel;
        orient_b ? pin_a_oe_n : pin_b_oe_n;
    endproperty
    a_pin_sel: assert property (p_pin_sel)
        else $error("unselected pin driven");
    property p_one_talk;
        far_oe_n || s_oe_n;
    endproperty
    a_one_talk: assert property (p_one_talk)
        else $error("two talkers on wire");
    property p_pre_low;
        $fell(s_oe_n) |-> !s_o;
    endproperty
    a_pre_low: assert property (p_pre_low)
        else $error("frame did not open low");
    property p_edge_due;
        !s_oe_n |-> d_cnt_reg <= U + 1;
    endproperty
    a_edge_due: assert property (p_edge_due)
        else $error("cell without edge");
    property p_run_len;
        (!s_oe_n && $past(!s_oe_n) && $changed(s_o)) |->
            d_cnt_reg inside {[U/2-3:U/2+1], [U-3:U+1]};
    endproperty
    a_run_len: assert property (p_run_len)
        else $error("bad run length");
    property p_far_pre;
        $fell(far_oe_n) |-> !far_o;
    endproperty
    a_far_pre: assert property (p_far_pre)
        else $error("far frame did not open low");
    property p_far_edge;
        !far_oe_n |-> f_cnt_reg <= U + 1;
    endproperty
    a_far_edge: assert property (p_far_edge)
        else $error("far cell without edge");
    property p_far_run;
        (!far_oe_n && $past(!far_oe_n) && $changed(far_o)) |->
            f_cnt_reg inside {[U/2-3:U/2+1], [U-3:U+1]};
    endproperty
    a_far_run: assert property (p_far_run)
        else $error("far bad run length");
endmodule
`default_nettype wire

// file: verif/usb_pd_bmc_phy_test.sv
// testbench: both link ends joined, random and corner messages
`default_nettype none
module usb_pd_bmc_phy_test;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // signals and instances
    // ****************************************
    logic clk = 0, srst = 1, att = 0, ori = 0, dir = 0;
    logic t_start = 0, t_bit = 0, t_last = 0;
    logic d_rdy, d_busy, d_rv, d_rb, idle, f_rdy, f_busy, f_rv, f_rb;
    int   errors = 0;
    int   comparisons = 0;
    logic q_d[$];
    logic q_f[$];
    upbp_link_if link();
    assign link.orient_b = ori;
    always #2 clk = ~clk;
    upbp_dev_end #(.UI_DIV(16), .IDLE(200)) i_upbp_dev_end (
        .i_sys_clk(clk), .i_srst(srst), .link(link),
        .i_attached(att), .i_orient_b(ori),
        .i_tx_start(t_start & !dir), .i_tx_bit(t_bit),
        .i_tx_last(t_last), .o_tx_ready(d_rdy), .o_tx_busy(d_busy),
        .o_rx_valid(d_rv), .o_rx_bit(d_rb), .o_bus_idle(idle));
    upbp_far_end #(.UI(16)) i_upbp_far_end (
        .i_sys_clk(clk), .i_srst(srst), .link(link),
        .i_tx_start(t_start & dir), .i_tx_bit(t_bit),
        .i_tx_last(t_last), .o_tx_ready(f_rdy), .o_tx_busy(f_busy),
        .o_rx_valid(f_rv), .o_rx_bit(f_rb));
    upbp_checker #(.U(16)) i_upbp_checker (
        .i_sys_clk(clk), .i_srst(srst),
        .pin_a_o(link.pin_a_o), .pin_a_oe_n(link.pin_a_oe_n),
        .pin_b_o(link.pin_b_o), .pin_b_oe_n(link.pin_b_oe_n),
        .far_o(link.far_o), .far_oe_n(link.far_oe_n),
        .orient_b(link.orient_b));
    always @(posedge clk)
    begin
        if (d_rv === 1'b1)
            q_d.push_back(d_rb);
        if (f_rv === 1'b1)
            q_f.push_back(f_rb);
    end
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic exp_bit(input logic [15:0] p, input int i);
        return p[i];
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // bit data held until the ready cycle takes it
    task automatic send(input logic dr, input int n, input logic [15:0] p);
        int k;
        dir = dr;
        q_d.delete();
        q_f.delete();
        t_start = 1;
        t_bit = p[0];
        t_last = (n == 1);
        @(posedge clk);
        #1 t_start = 0;
        @(posedge clk);
        #1 chk(idle, 16'h0);
        for (int i = 1; i < n; i++)
        begin
            t_bit = p[i];
            t_last = (i == n - 1);
            k = 0;
            @(negedge clk);
            while ((dr ? f_rdy : d_rdy) !== 1'b1 && k < 400)
            begin
                @(negedge clk);
                k++;
            end
            chk(16'(k < 400), 16'h1);
            @(posedge clk);
            #1;
        end
        k = 0;
        while ((dr ? f_busy : d_busy) !== 1'b0 && k < 1000)
        begin
            @(posedge clk);
            k++;
        end
        chk(16'(k < 1000), 16'h1);
        repeat (40) @(posedge clk);
        #1 chk(link.pin_a_oe_n & link.pin_b_oe_n, 16'h1);
        // the device's low preamble cell arrives as one leading zero
        if (!dr && q_f.size() > 0)
            chk(16'(q_f.pop_front()), 16'h0);
        chk(16'(dr ? q_d.size() : q_f.size()), 16'(n));
        for (int i = 0; i < n; i++)
            chk(dr ? q_d[i] : q_f[i], exp_bit(p, i));
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        int          n;
        logic [15:0] p;
        void'($urandom(32'h27528805));
        repeat (2) @(posedge clk);
        #1 srst = 0;
        chk(d_busy, 16'h0);
        chk(link.pin_a_oe_n & link.pin_b_oe_n, 16'h1);
        chk(idle, 16'h0);
        repeat (220) @(posedge clk);
        #1 chk(idle, 16'h1);
        // start while detached must be ignored
        t_start = 1;
        @(posedge clk);
        #1 t_start = 0;
        @(posedge clk);
        #1 chk(d_busy, 16'h0);
        for (int m = 0; m < 10; m++)
        begin
            att = 0;
            ori = 1'($urandom);
            @(posedge clk);
            #1 att = 1;
            n = (m == 0 || m == 1) ? 1 : (m < 4) ? 16 : $urandom_range(16, 1);
            p = (m == 2) ? 16'hFFFF : (m == 3) ? 16'h0000 : 16'($urandom);
            send(m[0], n, p);
        end
        end_sim();
    end
    initial
    begin
        #100000;
        errors++;
        end_sim();
    end
endmodule
`default_nettype wire
